//--- hdl/dlp_host.sv
// Purpose: host controller driving a parallel-load converter port
// Assumes: one converter, select strobe owned here, no read-back pins
// Notes:   writes complete on latch_strobe_n rising with select low
//
// Notes on behaviour
// [R1] device samples both setting lines with every write
// [R2] load strobe low applies settings and code together
// [R3] host bus is wider than the code to carry the settings
// [R4] wide bus: code right-justified, settings in top two bits
// [R5] shared setting lines; each device latches only when selected
// [R6] byte variant uses only low four bits of upper byte as code
// [R7] byte bus: bit 6 carries doubling, bit 7 carries reference buffer
// [R8] byte variant: low byte, then upper byte, then load strobe
// [R9] low-byte write also latches bits 6 and 7, later overwritten
// [R10] upper-byte write stores bits 0..3 as code 8..11
// [R11] write is select low with latch strobe rising; byte chosen by select
// [R12] load strobe low during write loads both registers
// [R13] device powers up cleared, unbuffered, unity range
// [R14] upper_byte_select steers each write to upper or lower byte
// [R15] wipe_n low clears every device register
// [R16] applied settings hold until the next load strobe
`default_nettype none
module dlp_host (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   output logic [15:0]      bus_bit,
   output logic             chip_select_n,
   output logic             latch_strobe_n,
   output logic             dac_load_strobe_n,
   output logic             upper_byte_select,
   output logic             wipe_n
);
   logic [15:0] code_reg;
   logic        cfg_bytewide;
   logic [3:0]  ctrl_pulse;
   logic [15:0] status;
   dlp_pkg::dlp_state_t state;
   dlp_pkg::dlp_state_t next_state;
   logic        phase_upper;
   logic        load_with_write;
   logic        tmr_start;
   logic [3:0]  tmr_len;
   logic        tmr_done;
   logic [15:0] shadow_applied;

   dlp_regs u_regs (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .addr         (addr),
      .wdata        (wdata),
      .wr           (wr),
      .rd           (rd),
      .status       (status),
      .rdata        (rdata),
      .code_reg     (code_reg),
      .cfg_bytewide (cfg_bytewide),
      .ctrl_pulse   (ctrl_pulse)
   );

   dlp_timer #(.W(4)) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (tmr_start),
      .len     (tmr_len),
      .done    (tmr_done)
   );

   // decoded commands; a command while busy is dropped
   wire busy      = (state != dlp_pkg::ST_IDLE);
   wire cmd_wr    = ctrl_pulse[dlp_pkg::CTRL_WRITE] && !busy;
   wire cmd_load  = ctrl_pulse[dlp_pkg::CTRL_LOAD] && !busy;
   wire cmd_wipe  = ctrl_pulse[dlp_pkg::CTRL_WIPE] && !busy;
   wire cmd_wrld  = ctrl_pulse[dlp_pkg::CTRL_WRLOAD];

   // settings fields held by software
   wire set_double = code_reg[dlp_pkg::POS_DOUBLE];
   wire set_refbuf = code_reg[dlp_pkg::POS_REFBUF];

   // wide word: code from bit 0, settings in the top two bits
   wire [15:0] wide_word = {set_refbuf, set_double, 2'b00,
                            code_reg[dlp_pkg::CODE_W-1:0]}; // [R3] [R4]

   // byte words; low byte is pure code, upper byte carries settings
   wire [15:0] low_word  = {8'h00, code_reg[7:0]};        // [R8]
   wire [15:0] high_word = {8'h00, set_refbuf, set_double, 2'b00,
                            code_reg[11:8]};              // [R7] [R10]

   // code bits 7:6 land in the device settings on the low write;
   // harmless, the upper write overwrites them before any load
   wire [15:0] drive_word = !cfg_bytewide ? wide_word :
                            (phase_upper ? high_word : low_word);

   // status word for software
   assign status = {shadow_applied[15:14], 12'h000, cfg_bytewide, busy};

   // sequencer
   always_comb begin
      next_state = state;
      tmr_start  = 1'b0;
      tmr_len    = 4'(dlp_pkg::SETUP_CYC);
      case (state)
         dlp_pkg::ST_IDLE: begin
            if (cmd_wipe) begin
               next_state = dlp_pkg::ST_WIPE;
               tmr_start  = 1'b1;
               tmr_len    = 4'(dlp_pkg::PULSE_CYC);
            end else if (cmd_wr) begin
               next_state = dlp_pkg::ST_SETUP;
               tmr_start  = 1'b1;
            end else if (cmd_load) begin
               next_state = dlp_pkg::ST_LOAD;
               tmr_start  = 1'b1;
               tmr_len    = 4'(dlp_pkg::PULSE_CYC);
            end
         end
         dlp_pkg::ST_SETUP: begin
            if (tmr_done) begin
               next_state = dlp_pkg::ST_WRLOW;
               tmr_start  = 1'b1;
               tmr_len    = 4'(dlp_pkg::PULSE_CYC);
            end
         end
         dlp_pkg::ST_WRLOW: begin
            if (tmr_done) begin
               next_state = dlp_pkg::ST_HOLD;
               tmr_start  = 1'b1;
            end
         end
         dlp_pkg::ST_HOLD: begin
            if (tmr_done) begin
               if (cfg_bytewide && !phase_upper) begin
                  next_state = dlp_pkg::ST_GAP; // [R8]
                  tmr_start  = 1'b1;
               end else if (load_with_write) begin
                  next_state = dlp_pkg::ST_IDLE;
               end else begin
                  next_state = dlp_pkg::ST_IDLE;
               end
            end
         end
         dlp_pkg::ST_GAP: begin
            if (tmr_done) begin
               next_state = dlp_pkg::ST_SETUP;
               tmr_start  = 1'b1;
            end
         end
         dlp_pkg::ST_LOAD, dlp_pkg::ST_WIPE: begin
            if (tmr_done) next_state = dlp_pkg::ST_IDLE;
         end
         default: next_state = dlp_pkg::ST_IDLE;
      endcase
   end

   // state register and sequence flags
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state           <= dlp_pkg::ST_IDLE;
         phase_upper     <= 1'b0;
         load_with_write <= 1'b0;
      end else begin
         state <= next_state;
         if (state == dlp_pkg::ST_IDLE && cmd_wr) begin
            phase_upper     <= 1'b0;
            load_with_write <= cmd_wrld;
         end else if (state == dlp_pkg::ST_HOLD && tmr_done) begin
            // set before the gap so bus and byte select settle early
            phase_upper <= cfg_bytewide && !phase_upper; // [R8]
         end
      end
   end

   // final write of a sequence, where a write-with-load applies all
   wire last_write = !cfg_bytewide || phase_upper;
   wire frame_next = (next_state == dlp_pkg::ST_SETUP) ||
                     (next_state == dlp_pkg::ST_WRLOW) ||
                     (next_state == dlp_pkg::ST_HOLD);
   // load stays low past the latch rise so the device sees a write
   // under load, not a race between the two rising edges
   wire load_next  = (next_state == dlp_pkg::ST_LOAD) ||
                     (load_with_write && last_write &&
                      (next_state == dlp_pkg::ST_WRLOW ||
                       next_state == dlp_pkg::ST_HOLD));

   // pin drive; chip select framed around each write only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus_bit           <= 16'h0000;
         chip_select_n     <= 1'b1;
         latch_strobe_n    <= 1'b1;
         dac_load_strobe_n <= 1'b1;
         upper_byte_select <= 1'b0;
         wipe_n            <= 1'b1;
      end else begin
         bus_bit           <= drive_word;
         upper_byte_select <= cfg_bytewide && phase_upper; // [R14] [R11]
         chip_select_n     <= !frame_next; // [R5]
         latch_strobe_n    <= !(next_state == dlp_pkg::ST_WRLOW); // [R11]
         dac_load_strobe_n <= !load_next; // [R12]
         wipe_n            <= !(next_state == dlp_pkg::ST_WIPE); // [R15]
      end
   end

   // mirror of the settings the device is now applying
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shadow_applied <= 16'h0000; // [R13]
      end else if (state == dlp_pkg::ST_WIPE) begin
         shadow_applied <= 16'h0000; // [R15]
      end else if (!dac_load_strobe_n && state != dlp_pkg::ST_WRLOW) begin
         shadow_applied <= {set_refbuf, set_double, 14'h0000}; // [R2] [R16]
      end else if (!dac_load_strobe_n && last_write) begin
         shadow_applied <= {set_refbuf, set_double, 14'h0000}; // [R1] [R12]
      end
   end
endmodule
`default_nettype wire

//--- hdl/dlp_pkg.sv
// Purpose: shared constants for the converter parallel-port controller
// Assumes: 20 MHz sys_clk, register port driven by local software
// Notes:   timing counts derive from nanosecond figures
`default_nettype none
package dlp_pkg;
   // software register addresses
   localparam logic [3:0] ADDR_CODE   = 4'h0; // code and settings
   localparam logic [3:0] ADDR_CTRL   = 4'h1; // command bits
   localparam logic [3:0] ADDR_STATUS = 4'h2; // busy and shadow state
   localparam logic [3:0] ADDR_CFG    = 4'h3; // mode selection
   // field positions in the code register
   localparam int CODE_W        = 12;
   localparam int POS_DOUBLE    = 12;
   localparam int POS_REFBUF    = 13;
   // control bits
   localparam int CTRL_WRITE    = 0;
   localparam int CTRL_LOAD     = 1;
   localparam int CTRL_WIPE     = 2;
   localparam int CTRL_WRLOAD   = 3;
   // configuration bits
   localparam int CFG_BYTEWIDE  = 0;
   // placement of settings on the bus
   localparam int WIDE_DOUBLE   = 14;
   localparam int WIDE_REFBUF   = 15;
   localparam int BYTE_DOUBLE   = 6;
   localparam int BYTE_REFBUF   = 7;
   // strobe timing
   localparam int CLK_NS        = 50;
   localparam int PULSE_NS      = 100;
   localparam int SETUP_NS      = 50;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   // reset values
   localparam logic [15:0] CODE_RST = 16'h0000;
   localparam logic        CFG_RST  = 1'b0;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_SETUP = 4'b0001,
      ST_WRLOW = 4'b0010,
      ST_HOLD  = 4'b0011,
      ST_GAP   = 4'b0100,
      ST_LOAD  = 4'b0101,
      ST_WIPE  = 4'b0110
   } dlp_state_t;
endpackage
`default_nettype wire

//--- hdl/dlp_regs.sv
// Purpose: software register port of the controller
// Assumes: strobes one cycle long, never together
// Notes:   read data valid only the cycle after the strobe
`default_nettype none
module dlp_regs (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [15:0] status,
   output logic [15:0]      rdata,
   output logic [15:0]      code_reg,
   output logic             cfg_bytewide,
   output logic [3:0]       ctrl_pulse
);
   wire sel_code = wr && (addr == dlp_pkg::ADDR_CODE);
   wire sel_ctrl = wr && (addr == dlp_pkg::ADDR_CTRL);
   wire sel_cfg  = wr && (addr == dlp_pkg::ADDR_CFG);
   logic [15:0] next_rdata;
   // unmapped addresses read zero
   always_comb begin
      case (addr)
         dlp_pkg::ADDR_CODE:   next_rdata = code_reg;
         dlp_pkg::ADDR_STATUS: next_rdata = status;
         dlp_pkg::ADDR_CFG:    next_rdata = {15'h0000, cfg_bytewide};
         default:              next_rdata = 16'h0000;
      endcase
   end
   // stores, command pulses and read return
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         code_reg     <= dlp_pkg::CODE_RST;
         cfg_bytewide <= dlp_pkg::CFG_RST;
         ctrl_pulse   <= 4'h0;
         rdata        <= 16'h0000;
      end else begin
         if (sel_code) code_reg <= wdata;
         if (sel_cfg) cfg_bytewide <= wdata[dlp_pkg::CFG_BYTEWIDE];
         ctrl_pulse <= sel_ctrl ? wdata[3:0] : 4'h0;
         rdata      <= rd ? next_rdata : 16'h0000;
      end
   end
endmodule
`default_nettype wire

//--- hdl/dlp_timer.sv
// Purpose: cycle down-counter for strobe widths
// Assumes: start wins over a running count
// Notes:   done is high in the last cycle of the count, so a state
//          started with len n lasts exactly n cycles
`default_nettype none
module dlp_timer #(
   parameter int W = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [W-1:0] len,
   output logic              done
);
   logic [W-1:0] cnt;
   logic         run;
   // done decoded, not registered: a registered flag adds a cycle
   assign done = run && (cnt == W'(1));
   // load on start, count down to zero and hold there
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt  <= '0;
         run  <= 1'b0;
      end else if (start) begin
         cnt  <= len;
         run  <= 1'b1;
      end else begin
         run  <= run && (cnt > 1);
         cnt  <= (cnt > 0) ? cnt - 1'b1 : cnt;
      end
   end
endmodule
`default_nettype wire

//--- test/dlp_dev_model.sv
// Purpose: behavioural converter port facing the host controller
// Assumes: byte_mode says which bus format is wired
// Notes:   clockless, acts on strobe edges only
`default_nettype none
module dlp_dev_model (
   input  wire logic        byte_mode,
   input  wire logic [15:0] bus_bit,
   input  wire logic        chip_select_n,
   input  wire logic        latch_strobe_n,
   input  wire logic        dac_load_strobe_n,
   input  wire logic        upper_byte_select,
   input  wire logic        wipe_n,
   output logic      [13:0] held,
   output logic      [13:0] applied
);
   timeunit 1ns;
   timeprecision 1ns;
   logic was_hi = 1'b1;
   // power-up: zero code, unbuffered, unity range
   initial begin
      held = 14'h0000;
      applied = 14'h0000;
   end
   // write on latch rise; settings taken like data bits
   always @(latch_strobe_n, negedge dac_load_strobe_n, negedge wipe_n) begin
      if (!wipe_n) begin
         held = 14'h0000;
         applied = 14'h0000;
      end else if (latch_strobe_n && !was_hi && !chip_select_n) begin
         if (!byte_mode) begin
            held = {bus_bit[15:14], bus_bit[11:0]};
         end else if (upper_byte_select) begin
            held = {bus_bit[7:6], bus_bit[3:0], held[7:0]};
         end else begin
            held = {bus_bit[7:6], held[11:8], bus_bit[7:0]};
         end
      end
      // load low is level: also catches a write under load
      if (wipe_n && !dac_load_strobe_n) begin
         applied = held;
      end
      was_hi = latch_strobe_n;
   end
endmodule
`default_nettype wire

//--- test/dlp_host_assertions.sv
// Purpose: port checks of the converter host controller
// Assumes: one clock domain, latch and wipe lows of two cycles, load lows of two or more
// Notes:   bound from the bench top file
`default_nettype none
module dlp_host_assertions (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [15:0] bus_bit,
   input wire logic        chip_select_n,
   input wire logic        latch_strobe_n,
   input wire logic        dac_load_strobe_n,
   input wire logic        upper_byte_select,
   input wire logic        wipe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // a write needs select low around the strobe
   latch_sel_a: assert property ($rose(latch_strobe_n) |-> !chip_select_n)
      else $error("latch rose unselected");
   cs_setup_a: assert property ($fell(latch_strobe_n) |-> $past(!chip_select_n))
      else $error("select late");
   cs_release_a: assert property ($rose(latch_strobe_n) |=> chip_select_n)
      else $error("select held");
   latch_width_a: assert property ($fell(latch_strobe_n) |=> !latch_strobe_n ##1 latch_strobe_n)
      else $error("latch width");
   // data, settings and byte steering frozen while latched
   bus_steady_a: assert property ((!latch_strobe_n || $rose(latch_strobe_n)) |-> $stable(bus_bit))
      else $error("bus moved");
   ubs_steady_a: assert property ((!latch_strobe_n || $rose(latch_strobe_n)) |-> $stable(upper_byte_select))
      else $error("byte select moved");
   load_width_a: assert property ($fell(dac_load_strobe_n) |=> !dac_load_strobe_n)
      else $error("load too short");
   wipe_width_a: assert property ($fell(wipe_n) |=> !wipe_n ##1 wipe_n)
      else $error("wipe width");
   upper_c: cover property ($rose(latch_strobe_n) && upper_byte_select);
   wrload_c: cover property (!dac_load_strobe_n && $rose(latch_strobe_n));
   wipe_c: cover property ($fell(wipe_n));
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: self-checking bench for the converter host controller
// Assumes: model format follows the CFG byte-wide bit
// Notes:   one byte-mode code has bits 7:6 apart from the settings
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        byte_mode = 1'b0;
   logic [15:0] rdata, bus_bit, s;
   logic        chip_select_n, latch_strobe_n, dac_load_strobe_n;
   logic        upper_byte_select, wipe_n;
   logic [13:0] held, applied;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   dlp_host i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .bus_bit(bus_bit),
      .chip_select_n(chip_select_n), .latch_strobe_n(latch_strobe_n),
      .dac_load_strobe_n(dac_load_strobe_n),
      .upper_byte_select(upper_byte_select), .wipe_n(wipe_n));
   dlp_dev_model i_dev (.byte_mode(byte_mode), .bus_bit(bus_bit),
      .chip_select_n(chip_select_n), .latch_strobe_n(latch_strobe_n),
      .dac_load_strobe_n(dac_load_strobe_n),
      .upper_byte_select(upper_byte_select), .wipe_n(wipe_n),
      .held(held), .applied(applied));
   // 20 MHz clock
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // hang guard, far above the hundred or so cycles used
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // command then bounded poll of the busy bit
   task automatic cmd(input logic [15:0] c);
      int i;
      wreg(dlp_pkg::ADDR_CTRL, c);
      for (i = 0; i < 20; i++) begin
         rreg(dlp_pkg::ADDR_STATUS, s);
         if (s[0] === 1'b0) break;
      end
   endtask
   task automatic stop_test;
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      check({2'b00, applied}, 16'h0000);
      rreg(4'hf, s);
      check(s, 16'h0000);
      rreg(dlp_pkg::ADDR_CODE, s);
      check(s, dlp_pkg::CODE_RST);
      // wide write held back until the load strobe
      wreg(dlp_pkg::ADDR_CODE, 16'h2abc);
      cmd(16'h0001);
      check({2'b00, held}, 16'h2abc);
      check({2'b00, applied}, 16'h0000);
      cmd(16'h0002);
      check({2'b00, applied}, 16'h2abc);
      rreg(dlp_pkg::ADDR_STATUS, s);
      check(s, 16'h8000);
      // write with the load strobe already low
      wreg(dlp_pkg::ADDR_CODE, 16'h1123);
      cmd(16'h0009);
      check({2'b00, applied}, 16'h1123);
      // byte-wide: low byte, upper byte, then load
      wreg(dlp_pkg::ADDR_CFG, 16'h0001);
      byte_mode <= 1'b1;
      wreg(dlp_pkg::ADDR_CODE, 16'h33c5);
      cmd(16'h0001);
      check({2'b00, held}, 16'h33c5);
      check({2'b00, applied}, 16'h1123);
      cmd(16'h0002);
      check({2'b00, applied}, 16'h33c5);
      rreg(dlp_pkg::ADDR_STATUS, s);
      check(s, 16'hc002);
      // load sent while busy is dropped
      wreg(dlp_pkg::ADDR_CODE, 16'h10bf);
      wreg(dlp_pkg::ADDR_CTRL, 16'h0001);
      cmd(16'h0002);
      check({2'b00, held}, 16'h10bf);
      check({2'b00, applied}, 16'h33c5);
      cmd(16'h0004);
      check({held, applied[1:0]}, 16'h0000);
      check({2'b00, applied}, 16'h0000);
      stop_test();
   end
endmodule
bind dlp_host dlp_host_assertions i_chk (.sys_clk(sys_clk), .rst(rst),
   .bus_bit(bus_bit), .chip_select_n(chip_select_n),
   .latch_strobe_n(latch_strobe_n), .dac_load_strobe_n(dac_load_strobe_n),
   .upper_byte_select(upper_byte_select), .wipe_n(wipe_n));
`default_nettype wire
